// ### include/pmt_pkg.sv
// package of constants for the period match timer
//
// Contract
// - count climbs from zero per tick; after matching period it returns to zero
// - period register is read/write and resets to all ones
// - prescaler bits 1:0: 00 divide 1, 01 divide 4, 1x divide 16
// - postscaler bits 6:3 divide matches by code plus one
// - each completed postscale count sets the latched match flag
// - count write, control write or reset clears prescaler and postscaler
// - control write leaves the count value unchanged
// - count register is read/write and resets to zero
// - control bit 2 runs the timer; zero stops it
// - control bit 7 reads zero; other control bits reset to zero
// - raw match pulse before postscaler is offered to the serial port
// - count and match are offered as the pwm time base
`default_nettype none
package pmt_pkg;
    // register byte offsets
    localparam logic [4:0] ADDR_COUNT   = 5'h00;
    localparam logic [4:0] ADDR_CONTROL = 5'h04;
    localparam logic [4:0] ADDR_PERIOD  = 5'h08;
    localparam logic [4:0] ADDR_STATUS  = 5'h0c;
    localparam logic [4:0] ADDR_MASK    = 5'h10;
    // control field positions
    localparam int CTL_PRE_LSB  = 0;
    localparam int CTL_RUN_BIT  = 2;
    localparam int CTL_POST_LSB = 3;
    localparam int CTL_POST_MSB = 6;
    // reset values
    localparam logic [7:0] COUNT_RST   = 8'h00;
    localparam logic [6:0] CONTROL_RST = 7'h00;
    localparam logic [7:0] PERIOD_RST  = 8'hff;
    localparam logic [3:0] PRE_RST     = 4'h0;
    localparam logic [3:0] POST_RST    = 4'h0;
    localparam logic       FLAG_RST    = 1'b0;
    localparam logic       MASK_RST    = 1'b0;
    // prescale terminal counts
    localparam logic [3:0] PRE_TC_1  = 4'h0;
    localparam logic [3:0] PRE_TC_4  = 4'h3;
    localparam logic [3:0] PRE_TC_16 = 4'hf;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pmt_pkg
`default_nettype wire

// ### rtl/pmt_prescale.sv
// input prescaler producing one-cycle tick enables
`timescale 1ns/100ps
`default_nettype none
module pmt_prescale (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // control
    input  wire logic       run_i,
    input  wire logic       clear_i,
    input  wire logic [1:0] sel_i,
    // tick out
    output logic            tick_o
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [3:0] tc;
    always_comb begin
        // 1x selects sixteen regardless of bit 0
        if (sel_i[1]) begin
            tc = pmt_pkg::PRE_TC_16;
        end else if (sel_i[0]) begin
            tc = pmt_pkg::PRE_TC_4;
        end else begin
            tc = pmt_pkg::PRE_TC_1;
        end
        tick_o  = run_i && !clear_i && (cnt_r >= tc);
        cnt_nxt = cnt_r;
        if (clear_i) begin
            cnt_nxt = 4'h0;
        end else if (run_i) begin
            cnt_nxt = (cnt_r >= tc) ? 4'h0 : cnt_r + 4'h1;
        end
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= pmt_pkg::PRE_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // pmt_prescale
`default_nettype wire

// ### rtl/pmt_timer.sv
// period match timer with axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none
module pmt_timer (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // axi write address
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_awaddr_i,
    // axi write data
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    // axi write response
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    output logic [1:0]       s_axi_bresp_o,
    // axi read address
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    input  wire logic [31:0] s_axi_araddr_i,
    // axi read data
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    // time base outputs
    output logic [7:0]       count_o,
    output logic             match_o,
    // interrupt
    output logic             irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    // write channel capture
    logic        aw_full_r, aw_full_nxt;
    logic        w_full_r, w_full_nxt;
    logic [4:0]  aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic        w_strb0_r, w_strb0_nxt;
    logic        b_valid_r, b_valid_nxt;
    logic [1:0]  b_resp_r, b_resp_nxt;
    logic        ar_valid_r, ar_valid_nxt;
    logic [31:0] r_data_r, r_data_nxt;
    logic [1:0]  r_resp_r, r_resp_nxt;
    logic        wr_go;
    logic        wr_hit;
    logic        wr_count, wr_control, wr_period, wr_status, wr_mask;

    // register state
    logic [7:0]  count_r, count_nxt;
    logic [6:0]  control_r, control_nxt;
    logic [7:0]  period_r, period_nxt;
    logic [3:0]  post_r, post_nxt;
    logic        flag_r, flag_nxt;
    logic        mask_r, mask_nxt;
    logic        match_r, match_nxt;
    logic        tick;
    logic        pre_clear;
    logic        raw_match;
    logic        run_enable;
    logic [1:0]  input_divider_select;
    logic [3:0]  output_divider_select;

    function automatic logic known_addr(input logic [4:0] a);
        known_addr = (a == pmt_pkg::ADDR_COUNT) || (a == pmt_pkg::ADDR_CONTROL) ||
                     (a == pmt_pkg::ADDR_PERIOD) || (a == pmt_pkg::ADDR_STATUS) ||
                     (a == pmt_pkg::ADDR_MASK);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus handshakes
    assign s_axi_awready_o = !aw_full_r && !b_valid_r;
    assign s_axi_wready_o  = !w_full_r && !b_valid_r;
    assign s_axi_arready_o = !ar_valid_r;
    assign s_axi_bvalid_o  = b_valid_r;
    assign s_axi_bresp_o   = b_resp_r;
    assign s_axi_rvalid_o  = ar_valid_r;
    assign s_axi_rdata_o   = r_data_r;
    assign s_axi_rresp_o   = r_resp_r;

    assign wr_go      = aw_full_r && w_full_r && !b_valid_r;
    // upper address bits must be zero too, else the write is refused
    assign wr_hit     = wr_go && known_addr(aw_addr_r) && w_strb0_r;
    assign wr_count   = wr_hit && (aw_addr_r == pmt_pkg::ADDR_COUNT);
    assign wr_control = wr_hit && (aw_addr_r == pmt_pkg::ADDR_CONTROL);
    assign wr_period  = wr_hit && (aw_addr_r == pmt_pkg::ADDR_PERIOD);
    assign wr_status  = wr_hit && (aw_addr_r == pmt_pkg::ADDR_STATUS);
    assign wr_mask    = wr_hit && (aw_addr_r == pmt_pkg::ADDR_MASK);

    // address and data may arrive in either order
    always_comb begin
        aw_full_nxt = aw_full_r;
        aw_addr_nxt = aw_addr_r;
        w_full_nxt  = w_full_r;
        w_data_nxt  = w_data_r;
        w_strb0_nxt = w_strb0_r;
        b_valid_nxt = b_valid_r;
        b_resp_nxt  = b_resp_r;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_full_nxt = 1'b1;
            aw_addr_nxt = (s_axi_awaddr_i[31:5] == 27'h0) ? s_axi_awaddr_i[4:0] : 5'h1f;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_full_nxt  = 1'b1;
            w_data_nxt  = s_axi_wdata_i;
            w_strb0_nxt = s_axi_wstrb_i[0];
        end
        if (wr_go) begin
            aw_full_nxt = 1'b0;
            w_full_nxt  = 1'b0;
            b_valid_nxt = 1'b1;
            // a write with lane 0 off is accepted and does nothing
            b_resp_nxt  = known_addr(aw_addr_r) ? pmt_pkg::RESP_OKAY : pmt_pkg::RESP_SLVERR;
        end else if (b_valid_r && s_axi_bready_i) begin
            b_valid_nxt = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel
    always_comb begin
        ar_valid_nxt = ar_valid_r;
        r_data_nxt   = r_data_r;
        r_resp_nxt   = r_resp_r;
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            ar_valid_nxt = 1'b1;
            r_resp_nxt   = pmt_pkg::RESP_OKAY;
            r_data_nxt   = 32'h0;
            if (s_axi_araddr_i[31:5] != 27'h0) begin
                r_resp_nxt = pmt_pkg::RESP_SLVERR;
            end else begin
                case (s_axi_araddr_i[4:0])
                    pmt_pkg::ADDR_COUNT:   r_data_nxt = {24'h0, count_r};
                    pmt_pkg::ADDR_CONTROL: r_data_nxt = {25'h0, control_r};
                    pmt_pkg::ADDR_PERIOD:  r_data_nxt = {24'h0, period_r};
                    pmt_pkg::ADDR_STATUS:  r_data_nxt = {31'h0, flag_r};
                    pmt_pkg::ADDR_MASK:    r_data_nxt = {31'h0, mask_r};
                    default:               r_resp_nxt = pmt_pkg::RESP_SLVERR;
                endcase
            end
        end else if (ar_valid_r && s_axi_rready_i) begin
            ar_valid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_full_r  <= 1'b0;
            aw_addr_r  <= 5'h00;
            w_full_r   <= 1'b0;
            w_data_r   <= 32'h0;
            w_strb0_r  <= 1'b0;
            b_valid_r  <= 1'b0;
            b_resp_r   <= 2'h0;
        end else begin
            aw_full_r  <= aw_full_nxt;
            aw_addr_r  <= aw_addr_nxt;
            w_full_r   <= w_full_nxt;
            w_data_r   <= w_data_nxt;
            w_strb0_r  <= w_strb0_nxt;
            b_valid_r  <= b_valid_nxt;
            b_resp_r   <= b_resp_nxt;
        end
    end

    // read side kept apart so a read never waits on a write
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ar_valid_r <= 1'b0;
            r_data_r   <= 32'h0;
            r_resp_r   <= 2'h0;
        end else begin
            ar_valid_r <= ar_valid_nxt;
            r_data_r   <= r_data_nxt;
            r_resp_r   <= r_resp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer core
    assign pre_clear = wr_count || wr_control;

    // control fields under their own names
    assign run_enable            = control_r[pmt_pkg::CTL_RUN_BIT];
    assign input_divider_select  = control_r[pmt_pkg::CTL_PRE_LSB +: 2];
    assign output_divider_select = control_r[pmt_pkg::CTL_POST_MSB:pmt_pkg::CTL_POST_LSB];

    pmt_prescale u_pre (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .run_i   (run_enable),
        .clear_i (pre_clear),
        .sel_i   (input_divider_select),
        .tick_o  (tick)
    );

    assign raw_match = tick && (count_r == period_r);

    ////////////////////////////////////////////////////////////////////////////
    // software settings: control, period and mask
    always_comb begin
        control_nxt = control_r;
        period_nxt  = period_r;
        mask_nxt    = mask_r;
        if (wr_control) begin
            // a new divider code only takes effect through the clear of this write
            control_nxt = w_data_r[6:0];
        end
        if (wr_period) begin
            period_nxt = w_data_r[7:0];
        end
        if (wr_mask) begin
            mask_nxt = w_data_r[0];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            control_r <= pmt_pkg::CONTROL_RST;
            period_r  <= pmt_pkg::PERIOD_RST;
            mask_r    <= pmt_pkg::MASK_RST;
        end else begin
            control_r <= control_nxt;
            period_r  <= period_nxt;
            mask_r    <= mask_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // count and raw match
    always_comb begin
        count_nxt = count_r;
        // match is registered so it lines up with the wrapped count
        match_nxt = raw_match;
        if (tick) begin
            // compare and wrap share the tick so the match lasts one tick
            count_nxt = (count_r == period_r) ? 8'h00 : count_r + 8'h01;
        end
        if (wr_count) begin
            count_nxt = w_data_r[7:0];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_r <= pmt_pkg::COUNT_RST;
            match_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            match_r <= match_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // postscaler and sticky flag
    always_comb begin
        post_nxt = post_r;
        flag_nxt = flag_r;
        if (wr_status && w_data_r[0]) begin
            flag_nxt = 1'b0;
        end
        if (pre_clear) begin
            post_nxt = pmt_pkg::POST_RST;
        end else if (raw_match) begin
            if (post_r == output_divider_select) begin
                post_nxt = pmt_pkg::POST_RST;
                // set beats a clear of the same cycle so no event is lost
                flag_nxt = 1'b1;
            end else begin
                post_nxt = post_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            post_r <= pmt_pkg::POST_RST;
            flag_r <= pmt_pkg::FLAG_RST;
        end else begin
            post_r <= post_nxt;
            flag_r <= flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign count_o = count_r;
    assign match_o = match_r;
    // level output: high while the flag is set and not masked off
    assign irq_o   = flag_r && mask_r;
endmodule // pmt_timer
`default_nettype wire

// ### test/pmt_timer_asserts.sv
// port assertions for the period match timer
`timescale 1ns/100ps
`default_nettype none
module pmt_timer_asserts (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rstn_i,
    // axi handshakes
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    // timer outputs
    input wire logic [7:0]  count_o,
    input wire logic        match_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic rd_take;
    assign rd_take = s_axi_arvalid_i && s_axi_arready_o;
    sequence wr_take_s;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence rd_take_s;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    // register writes land on the edge that raises bvalid
    count_step_a: assert property ($changed(count_o) |->
        count_o == $past(count_o) + 8'h01 || count_o == 8'h00 || $rose(s_axi_bvalid_o))
        else $error("count moved other than by one step");
    irq_hold_a: assert property ($fell(irq_o) |-> $rose(s_axi_bvalid_o))
        else $error("interrupt dropped without a write");
    wr_answer_a: assert property (wr_take_s |-> ##2 s_axi_bvalid_o)
        else $error("write response late");
    bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response not held");
    rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data not held");
    match_wrap_a: assert property (match_o |-> count_o == 8'h00)
        else $error("match pulse without a wrapped count");
    rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid_o)
        else $error("read answer late");
    rd_cause_a: assert property ($rose(s_axi_rvalid_o) |-> $past(rd_take))
        else $error("read answer without request");
endmodule // pmt_timer_asserts
bind pmt_timer pmt_timer_asserts u_chk (.*);
`default_nettype wire

// ### test/pmt_timer_tb.sv
// self-checking bench for the period match timer
`timescale 1ns/100ps
`default_nettype none
module pmt_timer_tb;
    logic        clk_i, rstn_i, match_o, irq_o;
    logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
    logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
    logic        s_axi_rvalid_o, s_axi_rready_i;
    logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i, q;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rsp;
    logic [7:0]  count_o, d, p, c0, mx;
    int          fails, samples_checked, n, k;
    pmt_timer DUT (.*);
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] ctl(input logic r, input logic [1:0] s, input logic [3:0] o);
        return {1'b0, o, r, s};
    endfunction
    function automatic int dv(input logic [1:0] s);
        return (s == 2'h0) ? 1 : (s == 2'h1) ? 4 : 16;
    endfunction
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %0t response %h expected %h", $time, g, e);
        end
    endtask
    // address and data are offered together, each dropped once taken
    task automatic wr(input logic [4:0] a, input logic [7:0] v,
                      input logic [1:0] er = pmt_pkg::RESP_OKAY,
                      input logic [3:0] st = 4'hf);
        logic pa, pw, ta, tw;
        @(posedge clk_i);
        s_axi_awaddr_i <= {27'h0, a};
        s_axi_wdata_i <= {24'h0, v};
        s_axi_wstrb_i <= st;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(negedge clk_i);
            ta = pa && s_axi_awready_o;
            tw = pw && s_axi_wready_o;
            @(posedge clk_i);
            pa = pa && !ta;
            pw = pw && !tw;
            s_axi_awvalid_i <= pa;
            s_axi_wvalid_i <= pw;
        end
        do @(negedge clk_i); while (s_axi_bvalid_o !== 1'b1);
        rsp = s_axi_bresp_o;
        @(posedge clk_i);
        s_axi_bready_i <= 1'b0;
        chk_r(rsp, er);
    endtask
    task automatic rd(input logic [4:0] a, input logic [1:0] er = pmt_pkg::RESP_OKAY);
        @(posedge clk_i);
        s_axi_araddr_i <= {27'h0, a};
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do @(negedge clk_i); while (s_axi_arready_o !== 1'b1);
        @(posedge clk_i);
        s_axi_arvalid_i <= 1'b0;
        do @(negedge clk_i); while (s_axi_rvalid_o !== 1'b1);
        d = s_axi_rdata_o[7:0];
        rsp = s_axi_rresp_o;
        @(posedge clk_i);
        s_axi_rready_i <= 1'b0;
        chk_r(rsp, er);
    endtask
    task automatic rc(input logic [4:0] a, input logic [7:0] e);
        rd(a);
        chk_v(d, e);
    endtask
    // counts raw match pulses while waiting
    task automatic cyc(input int m);
        repeat (m) begin
            @(negedge clk_i);
            k += (match_o === 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
        {s_axi_arvalid_i, s_axi_rready_i} = 2'h0;
        {s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i} = 96'h0;
        s_axi_wstrb_i = 4'hf;
        rstn_i = 1'b0;
        fails = 0;
        samples_checked = 0;
        k = $urandom(32'h9941);
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        rc(pmt_pkg::ADDR_COUNT, 8'h00);
        rc(pmt_pkg::ADDR_CONTROL, 8'h00);
        rc(pmt_pkg::ADDR_PERIOD, 8'hff);
        rc(pmt_pkg::ADDR_STATUS, 8'h00);
        rc(pmt_pkg::ADDR_MASK, 8'h00);
        rd(5'h14, pmt_pkg::RESP_SLVERR);
        wr(5'h14, 8'h00, pmt_pkg::RESP_SLVERR);
        wr(pmt_pkg::ADDR_CONTROL, 8'hff);
        rc(pmt_pkg::ADDR_CONTROL, 8'h7f);
        wr(pmt_pkg::ADDR_PERIOD, 8'h55, pmt_pkg::RESP_OKAY, 4'he);
        rc(pmt_pkg::ADDR_PERIOD, 8'hff);
        $display("test reset and control done");
        p = 8'($urandom);
        wr(pmt_pkg::ADDR_CONTROL, 8'h00);
        wr(pmt_pkg::ADDR_COUNT, p);
        wr(pmt_pkg::ADDR_CONTROL, ctl(1'b0, 2'h3, 4'h5));
        cyc(20);
        rc(pmt_pkg::ADDR_COUNT, p);
        @(negedge clk_i);
        chk_v(count_o, p);
        $display("test count hold done");
        // a window of whole prescale periods sees an exact number of ticks
        wr(pmt_pkg::ADDR_PERIOD, 8'hff);
        for (n = 0; n < 4; n++) begin
            wr(pmt_pkg::ADDR_COUNT, 8'h00);
            wr(pmt_pkg::ADDR_CONTROL, ctl(1'b1, n[1:0], 4'h0));
            @(negedge clk_i);
            c0 = count_o;
            cyc(8 * dv(n[1:0]));
            chk_v(count_o - c0, 8'h08);
        end
        repeat (5) begin
            wr(pmt_pkg::ADDR_COUNT, 8'h00);
            cyc(5);
        end
        chk_v(count_o, 8'h00);
        $display("test prescale done");
        p = 8'(2 + $urandom_range(0, 17));
        wr(pmt_pkg::ADDR_PERIOD, p);
        wr(pmt_pkg::ADDR_COUNT, 8'h00);
        wr(pmt_pkg::ADDR_CONTROL, ctl(1'b1, 2'h0, 4'h0));
        k = 0;
        mx = 8'h00;
        repeat (4 * (p + 1)) begin
            cyc(1);
            mx = (count_o > mx) ? count_o : mx;
        end
        chk_v(mx, p);
        chk_v(8'(k), 8'h04);
        $display("test period done");
        wr(pmt_pkg::ADDR_PERIOD, 8'h03);
        wr(pmt_pkg::ADDR_MASK, 8'h01);
        rc(pmt_pkg::ADDR_MASK, 8'h01);
        for (n = 0; n < 3; n++) begin
            q = (n == 0) ? 4'h0 : (n == 1) ? 4'hf : 4'($urandom_range(1, 14));
            wr(pmt_pkg::ADDR_CONTROL, ctl(1'b0, 2'h0, q));
            wr(pmt_pkg::ADDR_STATUS, 8'h01);
            wr(pmt_pkg::ADDR_COUNT, 8'h00);
            wr(pmt_pkg::ADDR_CONTROL, ctl(1'b1, 2'h0, q));
            k = 0;
            while (irq_o !== 1'b1)
                cyc(1);
            cyc(2);
            chk_v(8'(k), 8'(q) + 8'h01);
            cyc(70);
            chk_v(8'(irq_o), 8'h01);
            wr(pmt_pkg::ADDR_CONTROL, ctl(1'b0, 2'h0, q));
            wr(pmt_pkg::ADDR_MASK, 8'h00);
            @(negedge clk_i);
            chk_v(8'(irq_o), 8'h00);
            rc(pmt_pkg::ADDR_STATUS, 8'h01);
            wr(pmt_pkg::ADDR_MASK, 8'h01);
            wr(pmt_pkg::ADDR_STATUS, 8'h01);
            rc(pmt_pkg::ADDR_STATUS, 8'h00);
            @(negedge clk_i);
            chk_v(8'(irq_o), 8'h00);
        end
        $display("test postscale and interrupt done");
        results;
    end
    // the whole sequence needs about a thousand cycles
    initial begin
        repeat (30000) @(posedge clk_i);
        fails++;
        results;
    end
endmodule // pmt_timer_tb
`default_nettype wire
